// file: hw/t24_defines.vh
// Register map, field positions and constants of the 24-bit timer
`ifndef T24_DEFINES_VH
`define T24_DEFINES_VH

// Register byte addresses
`define T24_ADDR_COUNT      32'hfff7fd00
`define T24_ADDR_CTRL       32'hfff7fd04
`define T24_ADDR_CAPVAL0    32'hfff7fd08
`define T24_ADDR_CAPVAL1    32'hfff7fd0c
`define T24_ADDR_CAPCTRL0   32'hfff7fd14
`define T24_ADDR_CAPCTRL1   32'hfff7fd18
`define T24_ADDR_PINIO      32'hfff7fd20
`define T24_ADDR_MATCHVAL   32'hfff7fd24
`define T24_ADDR_MATCHCTRL  32'hfff7fd2c

// Counter control fields
`define T24_DIV_HI          15
`define T24_DIV_LO          8
`define T24_SRC_BIT         2
`define T24_IRQEN_BIT       1
`define T24_FLAG_BIT        0
`define T24_DIV_FLOOR       8'h03
`define T24_CNT_MAX         24'hffffff

// Capture control fields
`define T24_CSEL_HI         5
`define T24_CSEL_LO         4
`define T24_EDGE_HI         3
`define T24_EDGE_LO         2
`define T24_EDGE_NONE       2'h0
`define T24_EDGE_RISE       2'h1
`define T24_EDGE_FALL       2'h2
`define T24_EDGE_BOTH       2'h3

// Capture pin register fields
`define T24_P0_DIR_BIT      0
`define T24_P0_OUT_BIT      1
`define T24_P0_IN_BIT       2
`define T24_P1_DIR_BIT      3
`define T24_P1_OUT_BIT      4
`define T24_P1_IN_BIT       5

// Reset values
`define T24_RST_DIV         8'h00
`define T24_RST_COUNT       24'h000000
`define T24_RST_DATA        32'h00000000

`endif

// file: hw/t24_capture.v
// One input-capture channel: source select, edge detect, latch and flag
`include "t24_defines.vh"

module t24_capture (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Capture sources: pin, serial receive 0, serial receive 1, sync pin
    input  wire [3:0]  sources,
    input  wire [23:0] count_now,
    // Register access
    input  wire        ctrl_wr,
    input  wire [5:0]  ctrl_wdata,
    input  wire        data_rd,
    output wire [5:0]  ctrl_rd,
    output wire [23:0] captured_value
);

    reg  [1:0]  capture_source_select_ff;
    reg  [1:0]  edge_select_ff;
    reg         capture_irq_enable_ff;
    reg         capture_event_flag_ff;
    reg  [23:0] captured_value_ff;
    reg  [3:0]  prev_sources_ff;
    wire        src_now;
    wire        src_prev;
    wire        rise;
    wire        fall;
    reg         hit;
    wire        flag_clr;
    wire        nxt_flag;

    // Every source keeps its own history so a select change makes no edge
    assign src_now  = sources[capture_source_select_ff];          // see R10
    assign src_prev = prev_sources_ff[capture_source_select_ff];
    assign rise     = src_now & ~src_prev;
    assign fall     = ~src_now & src_prev;

    // Qualify the edge against the programmed trigger mode
    always @* begin
        case (edge_select_ff)                                      // see R11
            `T24_EDGE_NONE: hit = 1'b0;
            `T24_EDGE_RISE: hit = rise;
            `T24_EDGE_FALL: hit = fall;
            `T24_EDGE_BOTH: hit = rise | fall;
            default:        hit = 1'b0;
        endcase
    end

    // Write-1 or a data read clears; a capture in the same cycle wins
    assign flag_clr = (ctrl_wr & ctrl_wdata[`T24_FLAG_BIT]) | data_rd;
    assign nxt_flag = hit | (capture_event_flag_ff & ~flag_clr); // see R13

    // Control, history and latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_source_select_ff <= 2'h0;
            edge_select_ff           <= `T24_EDGE_NONE;
            capture_irq_enable_ff    <= 1'b0;
            capture_event_flag_ff    <= 1'b0;
            captured_value_ff        <= `T24_RST_COUNT;
            prev_sources_ff          <= 4'h0;
        end else begin
            prev_sources_ff       <= sources;
            capture_event_flag_ff <= nxt_flag;
            if (ctrl_wr) begin
                capture_source_select_ff <=
                    ctrl_wdata[`T24_CSEL_HI:`T24_CSEL_LO];         // see R10
                edge_select_ff <=
                    ctrl_wdata[`T24_EDGE_HI:`T24_EDGE_LO];         // see R11
                capture_irq_enable_ff <=
                    ctrl_wdata[`T24_IRQEN_BIT];                    // see R12
            end
            if (hit) begin
                captured_value_ff <= count_now;                    // see R20
            end
        end
    end

    assign ctrl_rd = {capture_source_select_ff, edge_select_ff,
                      capture_irq_enable_ff, capture_event_flag_ff};
    assign captured_value = captured_value_ff;                     // see R09

endmodule

// file: hw/t24_timer.v
// 24-bit timer with two capture channels, one compare channel, APB slave
//
// Contract
// R01 - Registers are 32-bit, word aligned, accept byte, half and word writes.
// R02 - All registers readable and writable in any mode; powerdown not here.
// R03 - Count value register returns current 24-bit count, read-only.
// R04 - Divider field 15:8 sets tick period to divider plus one clocks.
// R05 - Divider never below three; programmed values under 3 act as 3.
// R06 - Control bit 2 selects internal clock at 0, fault-0 input at 1.
// R07 - Control bit 1 is the wrap interrupt enable, reset to 0.
// R08 - Wrap flag bit 0 sets on wrap, write-1 clears, set wins.
// R09 - Each capture channel has a read-only 24-bit captured value.
// R10 - Capture select 5:4: pin, serial rx 0, serial rx 1, sync pin.
// R11 - Edge field 3:2: none, rising, falling, both edges.
// R12 - Capture control bit 1 is the capture interrupt enable, reset 0.
// R13 - Capture flag sets on capture; write-1 or data read clears.
// R14 - Pin direction bits 0 and 3: input at 0, output at 1.
// R15 - Pin drive bits 1 and 4 set output level, reset 0.
// R16 - Read-only level bits 2 and 5 return sampled pin levels.
// R17 - Compare value register holds writable 24-bit value, reset zero.
// R18 - Match flag sets on match; write-1 or value rewrite clears.
// R19 - Counter advances per tick and wraps all ones to zero.
// R20 - Qualifying capture edge latches current count into channel.
// R21 - Match event when count equals the compare value.
//
// The implementer's own choice: the APB slave port.
`include "t24_defines.vh"

module t24_timer (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // External count clock and capture sources
    input  wire        fault0_in,
    input  wire        serial_receive_0,
    input  wire        serial_receive_1,
    input  wire        sync_pin,
    // Capture pin 0, two-way
    input  wire        cpin0_in,
    output wire        cpin0_out,
    output wire        cpin0_oe,
    // Capture pin 1, two-way
    input  wire        cpin1_in,
    output wire        cpin1_out,
    output wire        cpin1_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [31:0] prdata_ff;
    reg         pready_ff;
    reg         pslverr_ff;
    reg  [31:0] nxt_prdata;
    reg         nxt_pslverr;

    reg  [7:0]  tick_divider_ff;
    reg         clock_source_select_ff;
    reg         wrap_irq_enable_ff;
    reg         wrap_flag_ff;
    reg  [7:0]  div_count_ff;
    reg         fault0_prev_ff;
    reg  [23:0] count_value_ff;

    reg  [23:0] match_value_ff;
    reg         match_irq_enable_ff;
    reg         match_event_flag_ff;

    reg         cpin0_direction_ff;
    reg         cpin0_drive_ff;
    reg         cpin0_level_ff;
    reg         cpin1_direction_ff;
    reg         cpin1_drive_ff;
    reg         cpin1_level_ff;

    wire        wr_fire;
    wire        rd_fire;
    wire        wr_lane0;

    wire        wr_ctrl;
    wire        wr_match_val;
    wire        wr_match_ctrl;
    wire        wr_pin;
    wire        wr_cap0;
    wire        wr_cap1;

    wire        rd_cap0;
    wire        rd_cap1;

    wire [7:0]  eff_divider;
    wire        int_tick;
    wire        ext_tick;
    wire        tick;

    wire [23:0] nxt_count;
    wire        wrap_event;
    wire        match_event;

    wire        nxt_wrap_flag;
    wire        nxt_match_flag;
    wire [23:0] nxt_match_value;

    wire [5:0]  cap0_ctrl;
    wire [5:0]  cap1_ctrl;
    wire [23:0] cap0_value;
    wire [23:0] cap1_value;

    ////////////////////////////////////////////////////////////////////////
    // APB handshake

    // A transfer completes at the access edge with pready high
    assign wr_fire  = psel & penable & pready_ff & pwrite;
    assign rd_fire  = psel & penable & pready_ff & ~pwrite;
    assign wr_lane0 = wr_fire & pstrb[0];

    // Per-register write and read strobes; pin, match and capture control bits live in byte 0
    assign wr_ctrl       = wr_fire & (paddr == `T24_ADDR_CTRL);
    assign wr_match_val  = wr_fire & (paddr == `T24_ADDR_MATCHVAL);
    assign wr_match_ctrl = wr_lane0 & (paddr == `T24_ADDR_MATCHCTRL);
    assign wr_pin        = wr_lane0 & (paddr == `T24_ADDR_PINIO);
    assign wr_cap0       = wr_lane0 & (paddr == `T24_ADDR_CAPCTRL0);
    assign wr_cap1       = wr_lane0 & (paddr == `T24_ADDR_CAPCTRL1);

    assign rd_cap0       = rd_fire & (paddr == `T24_ADDR_CAPVAL0);
    assign rd_cap1       = rd_fire & (paddr == `T24_ADDR_CAPVAL1);

    // Read data is sampled in the setup cycle, so the read sees the state
    // one edge before completion; this costs no wait state
    always @* begin
        nxt_prdata  = `T24_RST_DATA;
        nxt_pslverr = 1'b0;
        case (paddr)
            `T24_ADDR_COUNT:     nxt_prdata[23:0] = count_value_ff; // see R03
            `T24_ADDR_CTRL: begin
                nxt_prdata[`T24_DIV_HI:`T24_DIV_LO] = tick_divider_ff;
                nxt_prdata[`T24_SRC_BIT]   = clock_source_select_ff;
                nxt_prdata[`T24_IRQEN_BIT] = wrap_irq_enable_ff;
                nxt_prdata[`T24_FLAG_BIT]  = wrap_flag_ff;
            end
            `T24_ADDR_CAPVAL0:   nxt_prdata[23:0] = cap0_value;     // see R09
            `T24_ADDR_CAPVAL1:   nxt_prdata[23:0] = cap1_value;     // see R09
            `T24_ADDR_CAPCTRL0:  nxt_prdata[5:0]  = cap0_ctrl;
            `T24_ADDR_CAPCTRL1:  nxt_prdata[5:0]  = cap1_ctrl;
            `T24_ADDR_PINIO: begin
                nxt_prdata[`T24_P0_DIR_BIT] = cpin0_direction_ff;
                nxt_prdata[`T24_P0_OUT_BIT] = cpin0_drive_ff;
                nxt_prdata[`T24_P0_IN_BIT]  = cpin0_level_ff;   // see R16
                nxt_prdata[`T24_P1_DIR_BIT] = cpin1_direction_ff;
                nxt_prdata[`T24_P1_OUT_BIT] = cpin1_drive_ff;
                nxt_prdata[`T24_P1_IN_BIT]  = cpin1_level_ff;   // see R16
            end
            `T24_ADDR_MATCHVAL:  nxt_prdata[23:0] = match_value_ff; // see R17
            `T24_ADDR_MATCHCTRL: begin
                nxt_prdata[`T24_IRQEN_BIT] = match_irq_enable_ff;
                nxt_prdata[`T24_FLAG_BIT]  = match_event_flag_ff;
            end
            default:             nxt_pslverr = 1'b1;
        endcase
    end

    // One-cycle answer: pready rises in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= `T24_RST_DATA;
        end else begin
            pready_ff  <= psel & ~penable & ~pready_ff;
            pslverr_ff <= psel & ~penable & nxt_pslverr;
            if (psel & ~penable & ~pwrite) begin
                prdata_ff <= nxt_prdata;                           // see R02
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Tick generation

    // Small divider values would let the counter outrun software
    assign eff_divider = (tick_divider_ff < `T24_DIV_FLOOR) ?
                         `T24_DIV_FLOOR : tick_divider_ff;         // see R05
    assign int_tick    = (div_count_ff >= eff_divider);            // see R04
    assign ext_tick    = fault0_in & ~fault0_prev_ff;
    assign tick        = clock_source_select_ff ?
                         ext_tick : int_tick;                      // see R06

    // Divider runs off the system clock; >= guards a shrunk divider value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count_ff   <= 8'h00;
            fault0_prev_ff <= 1'b0;
        end else begin
            fault0_prev_ff <= fault0_in;
            if (int_tick) begin
                div_count_ff <= 8'h00;
            end else begin
                div_count_ff <= div_count_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, wrap and match

    assign nxt_count   = count_value_ff + 24'h000001;              // see R19
    assign wrap_event  = tick & (count_value_ff == `T24_CNT_MAX);  // see R19
    // Match only when the count lands on the value, not every idle cycle
    assign match_event = tick & (nxt_count == match_value_ff);     // see R21

    // An event in the clearing cycle keeps its flag set

    assign nxt_wrap_flag = wrap_event |
        (wrap_flag_ff & ~(wr_ctrl & pstrb[0] &
                          pwdata[`T24_FLAG_BIT]));                 // see R08
    assign nxt_match_flag = match_event |
        (match_event_flag_ff &
         ~((wr_match_ctrl & pwdata[`T24_FLAG_BIT]) |
           (wr_match_val & (|pstrb[2:0]))));                       // see R18

    // Byte lanes of the compare value
    assign nxt_match_value = {
        pstrb[2] ? pwdata[23:16] : match_value_ff[23:16],
        pstrb[1] ? pwdata[15:8]  : match_value_ff[15:8],
        pstrb[0] ? pwdata[7:0]   : match_value_ff[7:0]};           // see R01

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_ff      <= `T24_RST_COUNT;
            wrap_flag_ff        <= 1'b0;
            match_event_flag_ff <= 1'b0;
            match_value_ff      <= `T24_RST_COUNT;                 // see R17
        end else begin
            wrap_flag_ff        <= nxt_wrap_flag;
            match_event_flag_ff <= nxt_match_flag;
            if (tick) begin
                count_value_ff <= nxt_count;                       // see R19
            end
            if (wr_match_val) begin
                match_value_ff <= nxt_match_value;                 // see R17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_divider_ff        <= `T24_RST_DIV;
            clock_source_select_ff <= 1'b0;
            wrap_irq_enable_ff     <= 1'b0;
            match_irq_enable_ff    <= 1'b0;
        end else begin
            if (wr_ctrl & pstrb[1]) begin
                tick_divider_ff <= pwdata[`T24_DIV_HI:`T24_DIV_LO]; // see R04
            end
            if (wr_ctrl & pstrb[0]) begin
                clock_source_select_ff <= pwdata[`T24_SRC_BIT];    // see R06
                wrap_irq_enable_ff     <= pwdata[`T24_IRQEN_BIT];  // see R07
            end
            if (wr_match_ctrl) begin
                match_irq_enable_ff <= pwdata[`T24_IRQEN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture pins

    // Levels are taken straight from the pins, which are clock-synchronous
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpin0_direction_ff <= 1'b0;
            cpin0_drive_ff     <= 1'b0;
            cpin1_direction_ff <= 1'b0;
            cpin1_drive_ff     <= 1'b0;
            cpin0_level_ff     <= 1'b0;
            cpin1_level_ff     <= 1'b0;
        end else begin
            cpin0_level_ff <= cpin0_in;                            // see R16
            cpin1_level_ff <= cpin1_in;                            // see R16
            if (wr_pin) begin
                cpin0_direction_ff <= pwdata[`T24_P0_DIR_BIT];     // see R14
                cpin0_drive_ff     <= pwdata[`T24_P0_OUT_BIT];     // see R15
                cpin1_direction_ff <= pwdata[`T24_P1_DIR_BIT];     // see R14
                cpin1_drive_ff     <= pwdata[`T24_P1_OUT_BIT];     // see R15
            end
        end
    end

    assign cpin0_out = cpin0_drive_ff;
    assign cpin0_oe  = cpin0_direction_ff;

    assign cpin1_out = cpin1_drive_ff;
    assign cpin1_oe  = cpin1_direction_ff;

    ////////////////////////////////////////////////////////////////////////
    // Capture channels; each channel's pin A is its own capture pin

    t24_capture u_cap0 (
        .pclk           (pclk),
        .presetn        (presetn),
        .sources        ({sync_pin, serial_receive_1,
                          serial_receive_0, cpin0_in}),
        .count_now      (count_value_ff),
        .ctrl_wr        (wr_cap0),
        .ctrl_wdata     (pwdata[5:0]),
        .data_rd        (rd_cap0),
        .ctrl_rd        (cap0_ctrl),
        .captured_value (cap0_value)
    );

    t24_capture u_cap1 (
        .pclk           (pclk),
        .presetn        (presetn),
        .sources        ({sync_pin, serial_receive_1,
                          serial_receive_0, cpin1_in}),
        .count_now      (count_value_ff),
        .ctrl_wr        (wr_cap1),
        .ctrl_wdata     (pwdata[5:0]),
        .data_rd        (rd_cap1),
        .ctrl_rd        (cap1_ctrl),
        .captured_value (cap1_value)
    );

endmodule

// file: test/t24_timer_chk.sv
// Port-level assertions on the 24-bit timer, bound to its top module
`include "t24_defines.vh"
module t24_timer_chk (
    // Clock and reset
    input logic        pclk,
    input logic        presetn,
    // APB slave side
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Capture pin drivers
    input logic        cpin0_out,
    input logic        cpin0_oe,
    input logic        cpin1_out,
    input logic        cpin1_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed write to the pin register, low byte enabled
    wire pin_wr = psel && penable && pready && pwrite && pstrb[0]
                  && paddr == `T24_ADDR_PINIO;

    ////////////////////////////////////////////////////////////////////////
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (
        psel && !penable && paddr[31:8] != 24'hfff7fd |=> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (
        psel && !penable && paddr == `T24_ADDR_CTRL |=> pready && !pslverr)
        else $error("mapped access refused");
    err_data_zero_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    pin_dir_a: assert property (pin_wr |=>
        cpin0_oe == $past(pwdata[0]) && cpin1_oe == $past(pwdata[3]))
        else $error("direction bits not applied");
    pin_drive_a: assert property (pin_wr |=>
        cpin0_out == $past(pwdata[1]) && cpin1_out == $past(pwdata[4]))
        else $error("drive bits not applied");
    pin_hold_a: assert property (!pin_wr |=>
        $stable({cpin0_oe, cpin0_out, cpin1_oe, cpin1_out}))
        else $error("pin control changed without a write");
endmodule

bind t24_timer t24_timer_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpin0_out(cpin0_out), .cpin0_oe(cpin0_oe),
    .cpin1_out(cpin1_out), .cpin1_oe(cpin1_oe));

// file: test/t24_far_side.sv
// Far-side model: capture sources, external count clock, pin wires
module t24_far_side (
    // Levels asked for: fault, sync, rx1, rx0, pin1, pin0
    input  logic [5:0] want,
    // Timer pin drivers
    input  logic       cpin0_out,
    input  logic       cpin0_oe,
    input  logic       cpin1_out,
    input  logic       cpin1_oe,
    // Lines seen by the timer
    output logic       fault0_in,
    output logic       sync_pin,
    output logic       serial_receive_1,
    output logic       serial_receive_0,
    output logic       cpin1_in,
    output logic       cpin0_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Plain source lines follow the requested level
    assign fault0_in        = want[5];
    assign sync_pin         = want[4];
    assign serial_receive_1 = want[3];
    assign serial_receive_0 = want[2];
    // The timer's driver wins the wire while its enable is high
    assign cpin1_in = cpin1_oe ? cpin1_out : want[1];
    assign cpin0_in = cpin0_oe ? cpin0_out : want[0];
endmodule

// file: test/t24_timer_tb.sv
// Self-checking bench for the 24-bit timer
`include "t24_defines.vh"
module t24_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
    logic [3:0]  pstrb = 4'h0;
    logic [5:0]  want = 6'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, f0, snc, rx1, rx0, p1i, p0i;
    wire         p0o, p0e, p1o, p1e;
    int          errors = 0, check_count = 0;

    always #12.5 pclk = ~pclk;

    t24_timer dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault0_in(f0), .serial_receive_0(rx0), .serial_receive_1(rx1),
        .sync_pin(snc), .cpin0_in(p0i), .cpin0_out(p0o), .cpin0_oe(p0e),
        .cpin1_in(p1i), .cpin1_out(p1o), .cpin1_oe(p1e));
    t24_far_side far (
        .want(want), .cpin0_out(p0o), .cpin0_oe(p0e), .cpin1_out(p1o),
        .cpin1_oe(p1e), .fault0_in(f0), .sync_pin(snc),
        .serial_receive_1(rx1), .serial_receive_0(rx0), .cpin1_in(p1i),
        .cpin0_in(p0i));

    ////////////////////////////////////////////////////////////////////////
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
        apb(1'h1, a, d, s);
    endtask
    task automatic rdr(input logic [31:0] a);
        apb(1'h0, a, 32'h0, 4'h0);
    endtask
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Source level change, then time for the edge detector to act
    task automatic set_src(input int b, input logic v);
        @(posedge pclk);
        want[b] <= v;
        repeat (3) @(posedge pclk);
    endtask
    task automatic ext(input int k);
        repeat (k) begin
            set_src(5, 1'h1);
            set_src(5, 1'h0);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] a [5] = '{`T24_ADDR_CTRL, `T24_ADDR_CAPCTRL0,
            `T24_ADDR_CAPCTRL1, `T24_ADDR_MATCHVAL, `T24_ADDR_MATCHCTRL};
        foreach (a[i]) begin
            rdr(a[i]);
            chk(rd, 32'h0);
        end
        rdr(`T24_ADDR_PINIO);
        chk(rd & 32'h1b, 32'h0);
        rdr(32'hfff7fd10);
        chk({rd[31:1], err}, 32'h1);
        rdr(32'h0);
        chk({rd[31:1], err}, 32'h1);
    endtask
    // Count advance over 60 cycles for several divider settings
    task automatic t_div();
        logic [7:0]  dv [4] = '{8'h0, 8'h2, 8'h4, 8'h9};
        logic [31:0] c;
        foreach (dv[i]) begin
            wr(`T24_ADDR_CTRL, {16'h0, dv[i], 8'h0}, 4'h2);
            rdr(`T24_ADDR_COUNT);
            c = rd;
            repeat (57) @(posedge pclk);
            rdr(`T24_ADDR_COUNT);
            chk(rd - c, 60 / ((dv[i] < 3 ? 3 : dv[i]) + 1));
        end
    endtask
    // External clock: no internal ticks, one count per fault-0 rise
    task automatic t_ext();
        logic [31:0] c;
        wr(`T24_ADDR_CTRL, 32'h6, 4'h1);
        rdr(`T24_ADDR_CTRL);
        chk(rd, 32'h906);
        rdr(`T24_ADDR_COUNT);
        c = rd;
        repeat (40) @(posedge pclk);
        ext(5);
        rdr(`T24_ADDR_COUNT);
        chk(rd, c + 5);
    endtask
    // Every source and edge mode on both channels; count steps once per case
    task automatic t_cap();
        logic [31:0] ca, va, c;
        int          b;
        for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 4; s++) begin
                ca = ch ? `T24_ADDR_CAPCTRL1 : `T24_ADDR_CAPCTRL0;
                va = ch ? `T24_ADDR_CAPVAL1 : `T24_ADDR_CAPVAL0;
                b = (s == 0) ? ch : s + 1;
                ext(1);
                rdr(`T24_ADDR_COUNT);
                c = rd;
                wr(ca, {26'h0, s[1:0], s[1:0], 2'h3}, 4'h1);
                set_src(b, 1'h1);
                rdr(ca);
                chk(rd, {26'h0, s[1:0], s[1:0], 1'h1, s[0]});
                if (s[0]) begin
                    rdr(va);
                    chk(rd, c);
                    rdr(ca);
                    chk(rd & 32'h1, 32'h0);
                end
                set_src(b, 1'h0);
                rdr(ca);
                chk(rd & 32'h1, {31'h0, s[1]});
                wr(ca, 32'h1, 4'h1);
                rdr(ca);
                chk(rd, 32'h0);
            end
        end
    endtask
    task automatic t_pin();
        wr(`T24_ADDR_PINIO, 32'h3, 4'h1);
        set_src(1, 1'h1);
        rdr(`T24_ADDR_PINIO);
        chk(rd, 32'h27);
        chk({p1o, p1e, p0o, p0e}, 32'h3);
        set_src(1, 1'h0);
        wr(`T24_ADDR_PINIO, 32'h3c, 4'h1);
        rdr(`T24_ADDR_PINIO);
        chk(rd, 32'h38);
    endtask
    // Compare value, match flag set, rewrite clear and write-one clear
    task automatic t_match();
        logic [31:0] c;
        rdr(`T24_ADDR_COUNT);
        c = rd;
        wr(`T24_ADDR_COUNT, ~c, 4'hf);
        rdr(`T24_ADDR_COUNT);
        chk(rd, c);
        wr(`T24_ADDR_MATCHVAL, 32'hffffffff, 4'h2);
        rdr(`T24_ADDR_MATCHVAL);
        chk(rd, 32'hff00);
        wr(`T24_ADDR_MATCHVAL, c + 2, 4'hf);
        ext(1);
        rdr(`T24_ADDR_MATCHCTRL);
        chk(rd, 32'h0);
        ext(1);
        rdr(`T24_ADDR_MATCHCTRL);
        chk(rd, 32'h1);
        wr(`T24_ADDR_MATCHVAL, c + 9, 4'hf);
        rdr(`T24_ADDR_MATCHCTRL);
        chk(rd, 32'h0);
        ext(7);
        rdr(`T24_ADDR_MATCHCTRL);
        chk(rd, 32'h1);
        wr(`T24_ADDR_MATCHCTRL, 32'h3, 4'h1);
        rdr(`T24_ADDR_MATCHCTRL);
        chk(rd, 32'h2);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_div();
        t_ext();
        t_cap();
        t_pin();
        t_match();
        print_verdict();
    end
    // Watchdog, well past the length of a clean run
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end
endmodule
